// file: rtl/swr_recorder.sv
`timescale 1ns/10ps
// Overview of operation
// - With no trigger pending the work page is overwritten continuously and nothing is saved.
// - In threshold mode a trigger is declared when the SI value rises above the threshold.
// - After a trigger the work page captures 360 s around the trigger point and is then saved.
// - On completion the page is kept and the lowest invalid page, or if none the stored page with the oldest trigger time, becomes the work page.
// - On completion the new page gets rank 1 and every other stored page drops one rank.
// - If SI is already above threshold when a new work page starts, that instant triggers a 360 s post capture.
// - Each of the eleven pages carries a header with trigger time, trigger SI value and rank.
// - Forced recording is taken only in standby and captures 360 s from the start trigger.
// - A new forced start during a forced recording restarts the capture from that moment.
// - On loss of clock data time returns to 00:00:00 January 1 2050 and minor failure holds until time is set.
// - On loss of waveform storage every recorded page is marked invalid.
// - From reset the block stays in minor failure until the clock is set.
// - Headers and work page selection stay fixed during a capture unless waveform storage is lost; other recording waits.
// - A threshold capture other than a fresh-page trigger holds 30 s before the trigger point and 330 s after it.
module swr_recorder #(
  parameter int TICK_CYCLES = swr_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire swr_pkg::swr_sample_t smp,
  input wire logic [swr_pkg::SI_W-1:0] thresh,
  input wire logic standby,
  input wire logic force_start,
  input wire logic clk_lost,
  input wire logic wave_lost,
  input wire logic time_wr,
  input wire logic [swr_pkg::TIME_W-1:0] time_val,
  input wire logic [swr_pkg::PAGE_W-1:0] hdr_sel,
  output swr_pkg::swr_wr_t wr,
  output swr_pkg::swr_hdr_t hdr_out,
  output logic [swr_pkg::PAGE_W-1:0] work_page,
  output logic busy,
  output logic minor_fail,
  output logic [swr_pkg::TIME_W-1:0] cur_time
);
  import swr_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    swr_state_t st;
    swr_hdr_t [NUM_PAGES-1:0] hdr;
    logic [PAGE_W-1:0] work;
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] post;
    logic [PTR_W-1:0] start;
    logic above;
    logic fresh;
    logic [TIME_W-1:0] now;
    logic [31:0] tick;
    logic minor;
    logic [TIME_W-1:0] ttime;
    logic [SI_W-1:0] tsi;
    swr_wr_t wr;
  } swr_regs_t;

  swr_regs_t q;
  swr_regs_t d;
  logic above_now;
  logic auto_trig;
  logic save;

  // Invalid pages are taken first, since they hold nothing worth keeping.
  function automatic logic [PAGE_W-1:0] oldest_page(input swr_hdr_t [NUM_PAGES-1:0] h,
                                                     input logic [PAGE_W-1:0] skip);
    logic [PAGE_W-1:0] best;
    logic found;
    logic best_inv;
    best = PAGE_RESET;
    found = 1'b0;
    best_inv = 1'b0;
    for (int i = 0; i < NUM_PAGES; i++) begin
      if (PAGE_W'(i) != skip) begin
        if (!h[i].valid && !best_inv) begin
          best = PAGE_W'(i);
          best_inv = 1'b1;
          found = 1'b1;
        end else if (h[i].valid && !best_inv && (!found || h[i].trig_time < h[best].trig_time)) begin
          best = PAGE_W'(i);
          found = 1'b1;
        end
      end
    end
    return best;
  endfunction : oldest_page

  function automatic logic [PTR_W-1:0] back_pre(input logic [PTR_W-1:0] p);
    if (p >= PTR_W'(PRE_SAMP)) begin
      return p - PTR_W'(PRE_SAMP);
    end
    return p + PTR_W'(CAP_SAMP - PRE_SAMP);
  endfunction : back_pre

  assign above_now = smp.si > thresh;
  assign auto_trig = (q.st == ST_FILL) && !standby && above_now && (!q.above || q.fresh);
  assign save = (q.st != ST_FILL) && smp.valid && (q.post == PTR_W'(1));

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d = q;
    d.wr.en = 1'b0;
    d.above = above_now;
    if (q.tick == TICK_CYCLES - 1) begin
      d.tick = '0;
      d.now = q.now + TIME_W'(1);
    end else begin
      d.tick = q.tick + 32'h1;
    end
    if (clk_lost) begin
      d.now = TIME_EPOCH;
      d.minor = 1'b1;
    end else if (time_wr) begin
      d.now = time_val;
      d.minor = 1'b0;
    end
    if (smp.valid) begin
      d.wr.en = 1'b1;
      d.wr.page = q.work;
      d.wr.addr = q.wptr;
      d.wr.data = smp.accel;
      d.wptr = (q.wptr == PTR_W'(CAP_SAMP - 1)) ? '0 : q.wptr + PTR_W'(1);
    end
    case (q.st)
      ST_FILL: begin
        if (standby && force_start) begin
          d.st = ST_FORCE;
          d.start = q.wptr;
          d.post = PTR_W'(CAP_SAMP);
          d.ttime = q.now;
          d.tsi = smp.si;
        end else if (auto_trig) begin
          d.st = ST_CAP;
          d.ttime = q.now;
          d.tsi = smp.si;
          if (q.fresh) begin
            d.start = q.wptr;
            d.post = PTR_W'(CAP_SAMP);
          end else begin
            d.start = back_pre(q.wptr);
            d.post = PTR_W'(POST_SAMP);
          end
        end
        d.fresh = 1'b0;
      end
      ST_CAP, ST_FORCE: begin
        if (q.st == ST_FORCE && force_start) begin
          d.start = q.wptr;
          d.post = PTR_W'(CAP_SAMP);
          d.ttime = q.now;
          d.tsi = smp.si;
        end else if (save) begin
          for (int i = 0; i < NUM_PAGES; i++) begin
            if (q.hdr[i].valid) begin
              d.hdr[i].rank = q.hdr[i].rank + RANK_W'(1);
            end
          end
          d.hdr[q.work] = '{valid: 1'b1, rank: RANK_NEW, trig_time: q.ttime, trig_si: q.tsi,
                            start: q.start};
          d.work = oldest_page(q.hdr, q.work);
          d.hdr[d.work].valid = 1'b0;
          d.wptr = '0;
          d.fresh = 1'b1;
          d.st = ST_FILL;
        end else if (smp.valid) begin
          d.post = q.post - PTR_W'(1);
        end
      end
      default: begin
        d.st = ST_FILL;
      end
    endcase
    if (wave_lost) begin
      for (int i = 0; i < NUM_PAGES; i++) begin
        d.hdr[i].valid = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
      q.st <= ST_FILL;
      q.work <= PAGE_RESET;
      q.now <= TIME_EPOCH;
      q.minor <= 1'b1;
      q.fresh <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  assign wr = q.wr;
  assign hdr_out = q.hdr[hdr_sel];
  assign work_page = q.work;
  assign busy = q.st != ST_FILL;
  assign minor_fail = q.minor;
  assign cur_time = q.now;

  // ****************************************
  // Checks
  // ****************************************
  sequence armed_s;
    q.st == ST_FILL && !standby && above_now && !q.above && !q.fresh && ce;
  endsequence

  sequence saving_s;
    save && ce && !force_start && !wave_lost;
  endsequence

  no_idle_save_a: assert property (@(posedge clk) disable iff (!resetn)
    q.st == ST_FILL && !auto_trig && !(standby && force_start) && !wave_lost
    |=> q.st == ST_FILL && $stable(q.hdr)) else $error("save while idle");
  trig_rise_a: assert property (@(posedge clk) disable iff (!resetn)
    armed_s |=> q.st == ST_CAP && q.post == PTR_W'(POST_SAMP)) else $error("trigger missed");
  pre_span_a: assert property (@(posedge clk) disable iff (!resetn)
    armed_s ##0 q.wptr >= PTR_W'(PRE_SAMP) |=> q.start == $past(q.wptr) - PTR_W'(PRE_SAMP))
    else $error("bad pre-trigger start");
  save_page_a: assert property (@(posedge clk) disable iff (!resetn)
    saving_s |=> q.hdr[$past(q.work)].valid && q.work != $past(q.work) && q.st == ST_FILL)
    else $error("page not retained");
  new_rank_a: assert property (@(posedge clk) disable iff (!resetn)
    saving_s |=> q.hdr[$past(q.work)].rank == RANK_NEW) else $error("new rank wrong");
  fresh_trig_a: assert property (@(posedge clk) disable iff (!resetn)
    auto_trig && q.fresh && ce && !force_start |=> q.post == PTR_W'(CAP_SAMP) && q.start == $past(q.wptr))
    else $error("fresh trigger wrong");
  force_entry_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(q.st == ST_FORCE) |-> $past(standby) && $past(force_start) && q.post == PTR_W'(CAP_SAMP))
    else $error("forced entry wrong");
  force_restart_a: assert property (@(posedge clk) disable iff (!resetn)
    q.st == ST_FORCE && force_start && ce |=> q.post == PTR_W'(CAP_SAMP) && q.st == ST_FORCE)
    else $error("forced restart missed");
  clock_loss_a: assert property (@(posedge clk) disable iff (!resetn)
    clk_lost && ce |=> q.now == TIME_EPOCH && minor_fail) else $error("clock loss not handled");
  wave_loss_a: assert property (@(posedge clk) disable iff (!resetn)
    wave_lost && ce |=> q.hdr[0].valid == 1'b0 && q.hdr[NUM_PAGES-1].valid == 1'b0)
    else $error("pages still valid");
  minor_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    minor_fail && !time_wr |=> minor_fail) else $error("minor failure dropped");
  cap_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    q.st == ST_CAP && !save && !wave_lost |=> $stable(q.work) && $stable(q.hdr))
    else $error("headers moved in capture");

endmodule : swr_recorder

// file: rtl/swr_pkg.sv
package swr_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_PAGES = 11;
  localparam int PAGE_W = 4;
  localparam int RANK_W = 4;
  localparam int TIME_W = 32;
  localparam int SI_W = 16;
  localparam int DATA_W = 16;
  localparam int PTR_W = 16;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int SEC_NS = 1_000_000_000;
  localparam int TICK_CYC = SEC_NS / CLK_PERIOD_NS;
  localparam int SAMPLE_HZ = 100;
  localparam int CAPTURE_S = 360;
  localparam int PRE_S = 30;
  localparam int POST_S = 330;
  localparam int CAP_SAMP = CAPTURE_S * SAMPLE_HZ;
  localparam int PRE_SAMP = PRE_S * SAMPLE_HZ;
  localparam int POST_SAMP = POST_S * SAMPLE_HZ;

  // ****************************************
  // Reset values and header encodings
  // ****************************************
  // Time is seconds elapsed since 00:00:00 on January 1, 2050.
  localparam logic [TIME_W-1:0] TIME_EPOCH = 32'h0000_0000;
  localparam logic [RANK_W-1:0] RANK_NEW = 4'h1;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 4'h0;

  typedef struct packed {
    logic valid;
    logic [RANK_W-1:0] rank;
    logic [TIME_W-1:0] trig_time;
    logic [SI_W-1:0] trig_si;
    logic [PTR_W-1:0] start;
  } swr_hdr_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] accel;
    logic [SI_W-1:0] si;
  } swr_sample_t;

  typedef struct packed {
    logic en;
    logic [PAGE_W-1:0] page;
    logic [PTR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } swr_wr_t;

  typedef enum logic [2:0] {
    ST_FILL = 3'b001,
    ST_CAP = 3'b010,
    ST_FORCE = 3'b100
  } swr_state_t;

endpackage : swr_pkg

// file: test/swr_src_model.sv
`timescale 1ns/10ps
// ****************************************
// Acceleration and SI source
// ****************************************
module swr_src_model (
  input wire logic clk,
  input wire logic run,
  input wire logic [swr_pkg::SI_W-1:0] si_lvl,
  output swr_pkg::swr_sample_t smp
);
  import swr_pkg::*;
  logic [DATA_W-1:0] cnt_q = 16'h0000;
  // Off-sample words are inverted so that stale data is never mistaken for a fresh sample.
  always @(posedge clk) begin
    cnt_q <= cnt_q + 16'h0001;
    smp.valid <= run;
    smp.accel <= run ? cnt_q : ~cnt_q;
    smp.si <= si_lvl;
  end
endmodule : swr_src_model

// file: test/seismic_waveform_recorder_bench.sv
`timescale 1ns/10ps
// ****************************************
// Recorder bench
// ****************************************
module seismic_waveform_recorder_bench;
  import swr_pkg::*;
  typedef struct packed {
    logic [SI_W-1:0] si;
    logic sb;
    logic frc;
    logic bsy;
  } swr_row_t;
  logic clk, resetn, ce, standby, force_start, clk_lost, wave_lost, time_wr, run, chg;
  logic [SI_W-1:0] thresh, si_lvl;
  logic [TIME_W-1:0] time_val, cur_time;
  logic [PAGE_W-1:0] hdr_sel, work_page;
  logic busy, minor_fail;
  swr_sample_t smp;
  swr_wr_t wr;
  swr_hdr_t hdr_out;
  int n_mismatch = 0;
  int n_checks = 0;
  int k;
  int t_addr;
  // The last row rises above the threshold after a row below it, so it must trigger.
  swr_row_t rows [5] = '{'{16'h0010, 1'b0, 1'b0, 1'b0}, '{16'h0064, 1'b0, 1'b0, 1'b0},
    '{16'h00c8, 1'b1, 1'b0, 1'b0}, '{16'h0010, 1'b0, 1'b1, 1'b0}, '{16'h00c8, 1'b0, 1'b0, 1'b1}};

  swr_src_model i_swr_src_model (.clk(clk), .run(run), .si_lvl(si_lvl), .smp(smp));
  swr_recorder #(.TICK_CYCLES(10)) i_swr_recorder (.clk(clk), .resetn(resetn), .ce(ce), .smp(smp),
    .thresh(thresh), .standby(standby), .force_start(force_start), .clk_lost(clk_lost),
    .wave_lost(wave_lost), .time_wr(time_wr), .time_val(time_val), .hdr_sel(hdr_sel), .wr(wr),
    .hdr_out(hdr_out), .work_page(work_page), .busy(busy), .minor_fail(minor_fail), .cur_time(cur_time));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  task automatic do_reset();
    resetn <= 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    chk("minor", minor_fail, 1'b1);
    chk("busy", busy, 1'b0);
    chk("page", work_page, PAGE_RESET);
    chk("hdr valid", hdr_out.valid, 1'b0);
  endtask : do_reset

  task automatic set_time(input logic [TIME_W-1:0] t);
    @(posedge clk);
    time_wr <= 1'b1;
    time_val <= t;
    @(posedge clk);
    time_wr <= 1'b0;
    @(negedge clk);
  endtask : set_time

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    #(95000 * 25);
    n_mismatch++;
    results();
  end

  initial begin
    {resetn, standby, force_start, clk_lost, wave_lost, time_wr, time_val, hdr_sel} = '0;
    {ce, run} = 2'b11;
    thresh = 16'h0064;
    si_lvl = 16'h0010;
    do_reset();
    set_time(32'h0000_0064);
    chk("time set", cur_time >= 32'h64 && cur_time < 32'h66, 1'b1);
    chk("minor", minor_fail, 1'b0);
    @(posedge clk);
    clk_lost <= 1'b1;
    @(posedge clk);
    clk_lost <= 1'b0;
    @(negedge clk);
    chk("time lost", cur_time < 32'h2, 1'b1);
    repeat (20) @(negedge clk);
    chk("minor", minor_fail, 1'b1);
    set_time(32'h0000_0200);
    // Let the write pointer pass the pre-trigger span so the 30 s look-back does not wrap.
    repeat (3100) @(posedge clk);
    foreach (rows[i]) begin
      @(posedge clk);
      si_lvl <= rows[i].si;
      standby <= rows[i].sb;
      force_start <= rows[i].frc;
      @(posedge clk);
      force_start <= 1'b0;
      repeat (3) @(negedge clk);
      chk("busy", busy, rows[i].bsy);
      chk("wr en", wr.en, 1'b1);
      chk("wr page", wr.page, 4'h0);
    end
    // One cycle after the trigger the write address is one past the trigger sample.
    t_addr = wr.addr;
    chg = 1'b0;
    for (k = 0; k < 40000 && busy === 1'b1; k++) begin
      @(negedge clk);
      if (busy === 1'b1 && (work_page !== 4'h0 || hdr_out.valid !== 1'b0)) chg = 1'b1;
    end
    chk("steady", chg, 1'b0);
    chk("post len", k > 32990 && k < 33010, 1'b1);
    chk("pre start", hdr_out.start, t_addr - 1 - PRE_SAMP);
    chk("saved", busy, 1'b0);
    chk("hdr valid", hdr_out.valid, 1'b1);
    chk("rank", hdr_out.rank, RANK_NEW);
    chk("trig si", hdr_out.trig_si, 16'h00c8);
    chk("moved", work_page === 4'h0, 1'b0);
    for (k = 0; k < 4 && busy !== 1'b1; k++) @(negedge clk);
    chk("retrigger", busy, 1'b1);
    @(posedge clk);
    wave_lost <= 1'b1;
    @(posedge clk);
    wave_lost <= 1'b0;
    @(negedge clk);
    chk("lost", hdr_out.valid, 1'b0);
    @(posedge clk);
    si_lvl <= 16'h0010;
    standby <= 1'b1;
    do_reset();
    for (int n = 0; n < 2; n++) begin
      @(posedge clk);
      force_start <= 1'b1;
      @(posedge clk);
      force_start <= 1'b0;
      @(negedge clk);
      chk("forced", busy, 1'b1);
      if (n == 0) repeat (5000) @(posedge clk);
    end
    for (k = 0; k < 36500 && busy === 1'b1; k++) @(negedge clk);
    chk("force len", k > 35990 && k < 36010, 1'b1);
    chk("rank", hdr_out.rank, RANK_NEW);
    results();
  end
endmodule : seismic_waveform_recorder_bench
